// [common/iapt_pkg.sv]
// shared constants and types for the instruction-address patch trap
`default_nettype none

package iapt_pkg;

    // ============================================================
    // widths and counts
    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 8;
    localparam int BUS_AW  = 16;
    localparam int NUM_CMP = 6;
    localparam int NUM_BYTE = 3;

    // ============================================================
    // substituted opcode
    localparam logic [7:0] TRAP_OPCODE = 8'h01;

    // ============================================================
    // detect-address registers: low byte at the offset, then middle, then high
    localparam logic [15:0] DET_OFS [NUM_CMP] = '{16'h79E0, 16'h79E3, 16'h79E6,
                                                 16'h79F0, 16'h79F3, 16'h79F6};
    localparam logic [23:0] DET_RST = 24'h00_0000;

    // ============================================================
    // control, status and observation registers
    localparam logic [15:0] CTRL_LOW_OFS  = 16'h79E9;
    localparam logic [15:0] CTRL_HIGH_OFS = 16'h79EA;
    localparam logic [15:0] STAT_OFS      = 16'h79EB;
    localparam logic [15:0] MASK_OFS      = 16'h79EC;
    localparam logic [15:0] LAST_OFS      = 16'h79ED;
    localparam logic [15:0] COUNT_OFS     = 16'h79EE;
    localparam logic [15:0] LATCH_OFS     = 16'h79F9;

    // enable bit of each comparator, counted over both control registers
    localparam int CTRL_HIGH_BASE = 8;
    localparam int EN_POS [NUM_CMP] = '{1, 3, 5, 9, 11, 13};
    localparam logic [7:0] CTRL_WR_MASK = 8'h2A;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [5:0] STAT_RST     = 6'h00;
    localparam logic [5:0] MASK_RST     = 6'h00;

    // default internal ROM window
    localparam logic [23:0] ROM_LO_DEF = 24'hFF_0000;
    localparam logic [23:0] ROM_HI_DEF = 24'hFF_FFFF;

    // ============================================================
    // fetch-slot state
    typedef enum logic [1:0] {
        IAPT_EMPTY   = 2'b01,
        IAPT_LATCHED = 2'b10
    } iapt_state_t;

endpackage

`default_nettype wire

// [logic/iapt_addr_cmp.sv]
// one address comparator gated by its enable and the rom window
`timescale 1ns/1ns
`default_nettype none

module iapt_addr_cmp #(
    parameter int WIDTH = 24
) (
    // operands
    input  wire logic             enable,
    input  wire logic             valid,
    input  wire logic             inRom,
    input  wire logic [WIDTH-1:0] detectAddr,
    input  wire logic [WIDTH-1:0] latchAddr,
    // result
    output var  logic             hit
);

    always_comb begin
        hit = enable && valid && inRom && (detectAddr == latchAddr);
    end

endmodule

`default_nettype wire

// [logic/iapt_detect_reg.sv]
// one 24-bit detect-address register with byte-wide writes
`timescale 1ns/1ns
`default_nettype none

module iapt_detect_reg (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        srst,
    // byte writes
    input  wire logic [iapt_pkg::NUM_BYTE-1:0] byteWr,
    input  wire logic [iapt_pkg::DATA_W-1:0]   wdata,
    // stored address
    output var  logic [iapt_pkg::ADDR_W-1:0]   value
);

    typedef struct packed {
        logic [iapt_pkg::ADDR_W-1:0] addr;
    } iapt_det_t;

    iapt_det_t q;
    iapt_det_t d;

    always_comb begin
        d = q;
        for (int b = 0; b < iapt_pkg::NUM_BYTE; b++) begin
            if (byteWr[b]) begin
                d.addr[b*8 +: 8] = wdata;
            end
        end
        if (srst) begin
            d.addr = iapt_pkg::DET_RST;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign value = q.addr;

endmodule

`default_nettype wire

// [logic/iapt_patch_trap.sv]
// instruction-address patch trap: address latch, six comparators, opcode substitution
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Contract
// - latch next instruction address every fetch
// - compare latch with all detectors, always
// - hit replaces next instruction with trap
// - six independent 24-bit detect registers
// - each detector has its own enable
// - low control bits 1,3,5 enable 0-2
// - high control bits 9,11,13 enable 3-5
// - enable 0 blocks, 1 allows detection
// - trap goes into the very next slot
// - match raises the dedicated trap interrupt only when its mask bit is set (mask resets to 0)
// - trap opcode is single byte 01h
// - only internal rom addresses may match

module iapt_patch_trap #(
    parameter logic [23:0] ROM_LO = iapt_pkg::ROM_LO_DEF,
    parameter logic [23:0] ROM_HI = iapt_pkg::ROM_HI_DEF
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        srst,
    // register port
    input  wire logic [iapt_pkg::BUS_AW-1:0] regAddr,
    input  wire logic [iapt_pkg::DATA_W-1:0] regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output var  logic [iapt_pkg::DATA_W-1:0] regRdata,
    // fetch path from the core
    input  wire logic                        nextAddrValid,
    input  wire logic [iapt_pkg::ADDR_W-1:0] nextAddr,
    input  wire logic                        instrValid,
    input  wire logic [iapt_pkg::DATA_W-1:0] instrByte,
    // decode path to the core
    output var  logic                        decValid,
    output var  logic [iapt_pkg::DATA_W-1:0] decByte,
    output var  logic                        trapInserted,
    // interrupt
    output var  logic                        irq
);

    // ============================================================
    // state

    typedef struct packed {
        iapt_pkg::iapt_state_t                st;
        logic [iapt_pkg::ADDR_W-1:0]          latchAddr;
        logic                                 latchInRom;
        logic [7:0]                           ctrlLow;
        logic [7:0]                           ctrlHigh;
        logic [iapt_pkg::NUM_CMP-1:0]         status;
        logic [iapt_pkg::NUM_CMP-1:0]         mask;
        logic [2:0]                           lastHit;
        logic [7:0]                           trapCount;
        logic [iapt_pkg::DATA_W-1:0]          rdata;
        logic                                 decValid;
        logic [iapt_pkg::DATA_W-1:0]          decByte;
        logic                                 trapPulse;
        logic                                 irq;
    } iapt_core_t;

    iapt_core_t q;
    iapt_core_t d;

    // ============================================================
    // decoded enables

    logic [iapt_pkg::NUM_CMP-1:0] enVec;

    always_comb begin
        enVec = '0;
        for (int i = 0; i < iapt_pkg::NUM_CMP; i++) begin
            if (iapt_pkg::EN_POS[i] < iapt_pkg::CTRL_HIGH_BASE) begin
                enVec[i] = q.ctrlLow[iapt_pkg::EN_POS[i]];
            end else begin
                enVec[i] = q.ctrlHigh[iapt_pkg::EN_POS[i] - iapt_pkg::CTRL_HIGH_BASE];
            end
        end
    end

    // ============================================================
    // detect registers and comparators

    logic [iapt_pkg::NUM_BYTE-1:0] detWr  [iapt_pkg::NUM_CMP];
    logic [iapt_pkg::ADDR_W-1:0]   detVal [iapt_pkg::NUM_CMP];
    logic [iapt_pkg::NUM_CMP-1:0]  hitVec;
    logic                          latched;

    assign latched = (q.st == iapt_pkg::IAPT_LATCHED);

    always_comb begin
        for (int i = 0; i < iapt_pkg::NUM_CMP; i++) begin
            for (int b = 0; b < iapt_pkg::NUM_BYTE; b++) begin
                detWr[i][b] = regWr &&
                              (regAddr == 16'(iapt_pkg::DET_OFS[i] + b));
            end
        end
    end

    // each detector keeps its own register and comparator
    for (genvar gi = 0; gi < iapt_pkg::NUM_CMP; gi++) begin : g_cmp
        iapt_detect_reg u_det (
            .clock  (clock),
            .srst   (srst),
            .byteWr (detWr[gi]),
            .wdata  (regWdata),
            .value  (detVal[gi])
        );

        iapt_addr_cmp #(
            .WIDTH (iapt_pkg::ADDR_W)
        ) u_cmp (
            .enable     (enVec[gi]),
            .valid      (latched),
            .inRom      (q.latchInRom),
            .detectAddr (detVal[gi]),
            .latchAddr  (q.latchAddr),
            .hit        (hitVec[gi])
        );
    end

    // ============================================================
    // lowest matching detector, for software diagnosis

    logic [2:0] firstHit;

    always_comb begin
        firstHit = '0;
        for (int i = iapt_pkg::NUM_CMP - 1; i >= 0; i--) begin
            if (hitVec[i]) begin
                firstHit = 3'(i);
            end
        end
    end

    // ============================================================
    // register decode

    logic                         wrCtrlLow;
    logic                         wrCtrlHigh;
    logic                         wrMask;
    logic                         wrCount;
    logic                         rdStat;
    logic                         trapNow;
    logic [iapt_pkg::NUM_CMP-1:0] setVec;

    // the status offset has no write decode, so a write there is dropped
    always_comb begin
        wrCtrlLow  = regWr && (regAddr == iapt_pkg::CTRL_LOW_OFS);
        wrCtrlHigh = regWr && (regAddr == iapt_pkg::CTRL_HIGH_OFS);
        wrMask     = regWr && (regAddr == iapt_pkg::MASK_OFS);
        wrCount    = regWr && (regAddr == iapt_pkg::COUNT_OFS);
        rdStat     = regRd && (regAddr == iapt_pkg::STAT_OFS);
    end

    // ============================================================
    // trap decision

    // the byte handed in now meets the address latched before it; every
    // hitting comparator raises its own flag, not just the reported one
    always_comb begin
        trapNow = instrValid && latched && (|hitVec);
        setVec  = trapNow ? hitVec : '0;
    end

    // ============================================================
    // rom window of the incoming address

    logic nextInRom;

    // judged when the address arrives, so the compare path stays short
    always_comb begin
        nextInRom = (nextAddr >= ROM_LO) && (nextAddr <= ROM_HI);
    end

    // ============================================================
    // byte view of the detect registers and the address latch

    logic                        wideHit;
    logic [iapt_pkg::DATA_W-1:0] wideByte;

    always_comb begin
        wideHit  = 1'b0;
        wideByte = '0;
        for (int i = 0; i < iapt_pkg::NUM_CMP; i++) begin
            for (int b = 0; b < iapt_pkg::NUM_BYTE; b++) begin
                if (regAddr == 16'(iapt_pkg::DET_OFS[i] + b)) begin
                    wideHit  = 1'b1;
                    wideByte = detVal[i][b*8 +: 8];
                end
            end
        end
        // the latch is read-only: software sees what the comparators see
        for (int b = 0; b < iapt_pkg::NUM_BYTE; b++) begin
            if (regAddr == 16'(iapt_pkg::LATCH_OFS + b)) begin
                wideHit  = 1'b1;
                wideByte = q.latchAddr[b*8 +: 8];
            end
        end
    end

    // ============================================================
    // next state

    always_comb begin
        d = q;
        d.decValid  = 1'b0;
        d.trapPulse = 1'b0;

        // fetch slot: the byte handed in with instrValid belongs to the
        // address latched before it; a hit turns it into the trap opcode
        if (instrValid) begin
            d.decValid = 1'b1;
            d.decByte  = instrByte;
            case (q.st)
                iapt_pkg::IAPT_EMPTY: begin
                    d.st = iapt_pkg::IAPT_EMPTY;
                end
                iapt_pkg::IAPT_LATCHED: begin
                    d.st = iapt_pkg::IAPT_EMPTY;
                    if (trapNow) begin
                        d.decByte   = iapt_pkg::TRAP_OPCODE;
                        d.trapPulse = 1'b1;
                        d.lastHit   = firstHit;
                        if (q.trapCount != 8'hFF) begin
                            d.trapCount = q.trapCount + 8'h01;
                        end
                    end
                end
                default: begin
                    d.st = iapt_pkg::IAPT_EMPTY;
                end
            endcase
        end

        // a new address always replaces the latch; when it comes with a
        // byte, that byte was judged against the old latch above
        if (nextAddrValid) begin
            d.latchAddr  = nextAddr;
            d.latchInRom = nextInRom;
            d.st         = iapt_pkg::IAPT_LATCHED;
        end

        // control writes keep only the enable bits, reserved bits stay zero;
        // a write replaces all three enables of its byte at once
        if (wrCtrlLow) begin
            d.ctrlLow = regWdata & iapt_pkg::CTRL_WR_MASK;
        end
        if (wrCtrlHigh) begin
            d.ctrlHigh = regWdata & iapt_pkg::CTRL_WR_MASK;
        end
        if (wrMask) begin
            d.mask = regWdata[iapt_pkg::NUM_CMP-1:0];
        end
        if (wrCount) begin
            d.trapCount = 8'h00;
        end

        // sticky match flags: a hit in the clearing read's cycle survives
        if (rdStat) begin
            d.status = setVec;
        end else begin
            d.status = q.status | setVec;
        end

        // read data, one cycle after the strobe, zero when unmapped
        d.rdata = '0;
        if (regRd) begin
            if (wideHit) begin
                d.rdata = wideByte;
            end
            case (regAddr)
                iapt_pkg::CTRL_LOW_OFS: begin
                    d.rdata = q.ctrlLow;
                end
                iapt_pkg::CTRL_HIGH_OFS: begin
                    d.rdata = q.ctrlHigh;
                end
                iapt_pkg::STAT_OFS: begin
                    d.rdata = {2'b00, q.status};
                end
                iapt_pkg::MASK_OFS: begin
                    d.rdata = {2'b00, q.mask};
                end
                iapt_pkg::LAST_OFS: begin
                    d.rdata = {5'b00000, q.lastHit};
                end
                iapt_pkg::COUNT_OFS: begin
                    d.rdata = q.trapCount;
                end
                default: begin
                    d.rdata = d.rdata;
                end
            endcase
        end

        d.irq = |(d.status & d.mask);

        // synchronous reset: nothing enabled, no trap pending
        if (srst) begin
            d.st         = iapt_pkg::IAPT_EMPTY;
            d.latchAddr  = '0;
            d.latchInRom = 1'b0;
            d.ctrlLow    = iapt_pkg::CTRL_RST;
            d.ctrlHigh   = iapt_pkg::CTRL_RST;
            d.status     = iapt_pkg::STAT_RST;
            d.mask       = iapt_pkg::MASK_RST;
            d.lastHit    = '0;
            d.trapCount  = 8'h00;
            d.rdata      = '0;
            d.decValid   = 1'b0;
            d.decByte    = '0;
            d.trapPulse  = 1'b0;
            d.irq        = 1'b0;
        end
    end

    // ============================================================
    // registers

    always_ff @(posedge clock) begin
        q <= d;
    end

    // ============================================================
    // outputs, each straight from a flip-flop

    assign regRdata     = q.rdata;
    assign decValid     = q.decValid;
    assign decByte      = q.decByte;
    assign trapInserted = q.trapPulse;
    assign irq          = q.irq;

endmodule

`default_nettype wire

// [verif/iapt_fetch_model.sv]
// model of the core fetch path feeding the patch trap
`timescale 1ns/1ns
`default_nettype none

module iapt_fetch_model (
    // clock
    input  wire logic        clock,
    // fetch path to the unit
    output var  logic        nextAddrValid,
    output var  logic [23:0] nextAddr,
    output var  logic        instrValid,
    output var  logic [7:0]  instrByte
);
    initial begin
        nextAddrValid = 1'b0;
        nextAddr      = 24'h00_0000;
        instrValid    = 1'b0;
        instrByte     = 8'h00;
    end

    // gap stretches the wait between address and byte, as a slow core would
    task automatic fetch(input logic [23:0] a, input logic [7:0] b, input int gap, input bit withAddr);
        if (withAddr) begin
            @(posedge clock);
            nextAddrValid <= 1'b1;
            nextAddr      <= a;
            @(posedge clock);
            nextAddrValid <= 1'b0;
            nextAddr      <= ~a;
        end else begin
            @(posedge clock);
        end
        repeat (gap) @(posedge clock);
        instrValid <= 1'b1;
        instrByte  <= b;
        @(posedge clock);
        instrValid <= 1'b0;
        instrByte  <= ~b;
    endtask
endmodule

`default_nettype wire

// [verif/iapt_patch_trap_properties.sv]
// port checker for the instruction-address patch trap, bound to its top
`timescale 1ns/1ns
`default_nettype none

module iapt_patch_trap_properties #(
    parameter logic [23:0] ROM_LO = iapt_pkg::ROM_LO_DEF,
    parameter logic [23:0] ROM_HI = iapt_pkg::ROM_HI_DEF
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdata,
    // fetch and decode path
    input wire logic        nextAddrValid,
    input wire logic [23:0] nextAddr,
    input wire logic        instrValid,
    input wire logic [7:0]  instrByte,
    input wire logic        decValid,
    input wire logic [7:0]  decByte,
    input wire logic        trapInserted,
    input wire logic        irq
);
    // ============================================================
    // helper: an address is waiting for its opcode byte
    logic pendQ;

    always_ff @(posedge clock) begin
        pendQ <= srst ? 1'b0 : (nextAddrValid ? 1'b1 : (instrValid ? 1'b0 : pendQ));
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // ============================================================
    // sequences and properties
    sequence outsideRomFetch;
        nextAddrValid && (nextAddr < ROM_LO || nextAddr > ROM_HI) ##1 !nextAddrValid && instrValid;
    endsequence

    sequence passedByte;
        instrValid ##1 !trapInserted;
    endsequence

    dec_follow_a: assert property (instrValid |=> decValid) else $error("decode pulse missing");
    dec_quiet_a: assert property (!instrValid |=> !decValid && !trapInserted) else $error("stray decode");
    trap_byte_a: assert property (trapInserted |-> decValid && decByte == iapt_pkg::TRAP_OPCODE)
        else $error("trap byte wrong");
    pass_byte_a: assert property (passedByte |-> decByte == $past(instrByte)) else $error("byte altered");
    rom_only_a: assert property (outsideRomFetch |=> !trapInserted) else $error("trap outside rom");
    no_latch_a: assert property (instrValid && !pendQ |=> !trapInserted) else $error("trap without address");
    rd_idle_a: assert property (!regRd |=> regRdata == 8'h00) else $error("read data not idle");
    ctrl_low_a: assert property (regRd && regAddr == iapt_pkg::CTRL_LOW_OFS |=>
        (regRdata & ~iapt_pkg::CTRL_WR_MASK) == 8'h00) else $error("low reserved bits set");
    ctrl_high_a: assert property (regRd && regAddr == iapt_pkg::CTRL_HIGH_OFS |=>
        (regRdata & ~iapt_pkg::CTRL_WR_MASK) == 8'h00) else $error("high reserved bits set");
endmodule

bind iapt_patch_trap iapt_patch_trap_properties #(.ROM_LO(ROM_LO), .ROM_HI(ROM_HI)) checkerInst (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .nextAddrValid(nextAddrValid), .nextAddr(nextAddr), .instrValid(instrValid),
    .instrByte(instrByte), .decValid(decValid), .decByte(decByte), .trapInserted(trapInserted), .irq(irq)
);

`default_nettype wire

// [verif/testbench.sv]
// self-checking testbench of the instruction-address patch trap
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic        clock = 1'b0;
    logic        srst  = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWdata = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  regRdata;
    logic        nextAddrValid;
    logic [23:0] nextAddr;
    logic        instrValid;
    logic [7:0]  instrByte;
    logic        decValid;
    logic [7:0]  decByte;
    logic        trapInserted;
    logic        irq;
    int          badCount = 0;
    int          checkCount = 0;

    always #50 clock = ~clock;

    iapt_patch_trap DUT (
        .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .nextAddrValid(nextAddrValid), .nextAddr(nextAddr), .instrValid(instrValid),
        .instrByte(instrByte), .decValid(decValid), .decByte(decByte), .trapInserted(trapInserted), .irq(irq)
    );

    iapt_fetch_model cpu (
        .clock(clock), .nextAddrValid(nextAddrValid), .nextAddr(nextAddr), .instrValid(instrValid),
        .instrByte(instrByte)
    );

    // ============================================================
    // shared tasks
    task automatic giveVerdict;
        if (badCount == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        check(regRdata, exp, what);
    endtask

    task automatic enable(input int i, input logic on);
        wr(i < 3 ? iapt_pkg::CTRL_LOW_OFS : iapt_pkg::CTRL_HIGH_OFS, 8'(on) << (iapt_pkg::EN_POS[i] % 8));
    endtask

    // tEach and the second call in tRom clear the enable first; the other calls rely on it already being off, so a half-written address never fires
    task automatic setDet(input int i, input logic [23:0] a);
        for (int k = 0; k < 3; k++) wr(iapt_pkg::DET_OFS[i] + 16'(k), a[8*k +: 8]);
    endtask

    task automatic fetchChk(input logic [23:0] a, input logic [7:0] b, input int gap, input logic hit,
                            input bit withAddr = 1'b1);
        cpu.fetch(a, b, gap, withAddr);
        #1;
        check(decValid, 8'h01, "decode valid");
        check(decByte, hit ? iapt_pkg::TRAP_OPCODE : b, "decode byte");
        check(trapInserted, hit, "trap flag");
    endtask

    // ============================================================
    // scenarios
    task automatic tReset;
        rdChk(iapt_pkg::CTRL_LOW_OFS, 8'h00, "low enables");
        rdChk(iapt_pkg::CTRL_HIGH_OFS, 8'h00, "high enables");
        rdChk(iapt_pkg::STAT_OFS, 8'h00, "status");
        rdChk(iapt_pkg::MASK_OFS, 8'h00, "mask");
        rdChk(16'h0000, 8'h00, "unmapped");
        wr(iapt_pkg::CTRL_LOW_OFS, 8'hFF);
        rdChk(iapt_pkg::CTRL_LOW_OFS, 8'h2A, "reserved dropped");
        wr(iapt_pkg::CTRL_LOW_OFS, 8'h00);
    endtask

    task automatic tEach;
        logic [23:0] a;
        for (int i = 0; i < iapt_pkg::NUM_CMP; i++) begin
            a = 24'hFF_0100 + 24'(i * 16);
            enable(i, 1'b0);
            setDet(i, a);
            enable(i, 1'b1);
            rdChk(i < 3 ? iapt_pkg::CTRL_LOW_OFS : iapt_pkg::CTRL_HIGH_OFS,
                  8'h01 << (iapt_pkg::EN_POS[i] % 8), "enable position");
            fetchChk(a, 8'h4A, i % 2, 1'b1);
            if (i > 0) fetchChk(a - 24'h00_0010, 8'h4B, 0, 1'b0);
            enable(i, 1'b0);
            fetchChk(a, 8'h4C, 0, 1'b0);
        end
    endtask

    task automatic tRom;
        setDet(0, 24'h00_1000);
        enable(0, 1'b1);
        fetchChk(24'h00_1000, 8'h4A, 0, 1'b0);
        enable(0, 1'b0);
        setDet(0, iapt_pkg::ROM_LO_DEF);
        enable(0, 1'b1);
        fetchChk(iapt_pkg::ROM_LO_DEF, 8'h4A, 1, 1'b1);
    endtask

    // all six detectors fired once in tEach and nothing has read status since
    task automatic tIrq;
        rdChk(iapt_pkg::STAT_OFS, 8'h3F, "status sticky");
        fetchChk(iapt_pkg::ROM_LO_DEF, 8'h33, 0, 1'b1);
        repeat (2) @(posedge clock);
        #1;
        check(irq, 8'h00, "masked irq");
        wr(iapt_pkg::MASK_OFS, 8'h01);
        #1;
        check(irq, 8'h01, "unmasked irq");
        rdChk(iapt_pkg::STAT_OFS, 8'h01, "status read");
        repeat (2) @(posedge clock);
        #1;
        check(irq, 8'h00, "irq after clear");
        rdChk(iapt_pkg::STAT_OFS, 8'h00, "status cleared");
    endtask

    // one latched address serves one byte only; a second byte must pass untouched
    task automatic tNoLatch;
        fetchChk(iapt_pkg::ROM_LO_DEF, 8'h5A, 0, 1'b0, 1'b0);
    endtask

    // two detectors on one address flag together; then a mid-run reset disarms all
    task automatic tDiag;
        logic [23:0] a = 24'hFF_0200;
        wr(iapt_pkg::COUNT_OFS, 8'h00);
        setDet(3, a);
        setDet(5, a);
        wr(iapt_pkg::CTRL_HIGH_OFS, 8'h22);
        fetchChk(a, 8'h77, 0, 1'b1);
        rdChk(iapt_pkg::STAT_OFS, 8'h28, "both flags");
        rdChk(iapt_pkg::LAST_OFS, 8'h03, "last hit");
        rdChk(iapt_pkg::COUNT_OFS, 8'h01, "trap count");
        for (int k = 0; k < 3; k++) rdChk(iapt_pkg::LATCH_OFS + 16'(k), a[8*k +: 8], "latch byte");
        rdChk(iapt_pkg::DET_OFS[5] + 16'h0002, 8'hFF, "detect high");
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rdChk(iapt_pkg::CTRL_HIGH_OFS, 8'h00, "enables after reset");
        rdChk(iapt_pkg::DET_OFS[5] + 16'h0002, 8'h00, "detect after reset");
        fetchChk(a, 8'h11, 0, 1'b0);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        tReset();
        tEach();
        tRom();
        tIrq();
        tNoLatch();
        tDiag();
        giveVerdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        badCount++;
        giveVerdict();
    end
endmodule

`default_nettype wire
